// ---- hdl/scfg_loader.sv ----
/*
  Strap loader and configuration unlock port: samples straps after each
  reset, holds the per-slot configuration registers and serves the
  index/data port pair over bus I/O cycles on the four-bit lines.
  Assumes the bus clock is i_sys_clk, the host follows the I/O cycle
  framing, and the straps are steady around reset release.
*/
`timescale 1ns/10ps
`include "scfg_map.svh"

module scfg_loader #(
  parameter int NSLOT = 5
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire scfg_pkg::scfg_strap_s i_strap,
  input wire logic i_lframe_n,
  input wire logic [3:0] i_lad,
  output logic [3:0] o_lad,
  output logic o_lad_oe,
  output logic o_cfg_open,
  output scfg_pkg::scfg_chan_s [NSLOT-1:0] o_chan_cfg
);

  scfg_pkg::scfg_state_e st, next_st;
  logic [15:0] addr, next_addr;
  logic wr, next_wr;
  logic [7:0] wdat, next_wdat;
  logic [7:0] rdat, next_rdat;
  logic [3:0] lad, next_lad;
  logic lad_oe, next_lad_oe;
  logic cmd_wr;
  logic loaded, next_loaded;
  logic open, next_open;
  logic key_seen, next_key_seen;
  logic [7:0] index, next_index;
  logic [7:0] ldn, next_ldn;
  logic [7:0] key, next_key;
  logic [15:0] port, next_port;
  scfg_pkg::scfg_chan_s [NSLOT-1:0] regs, next_regs;
  scfg_pkg::scfg_chan_s [4:0] dflt;
  logic [7:0] dkey;
  logic [15:0] dport;
  logic [2:0] slot;
  logic [7:0] rd_val;

  scfg_strap_dec u_dec (
    .i_strap(i_strap),
    .o_dflt(dflt),
    .o_key(dkey),
    .o_index_port(dport)
  );

  function automatic logic is_index(input logic [15:0] a,
                                    input logic [15:0] p);
    is_index = (a == p);
  endfunction

  function automatic logic is_data(input logic [15:0] a,
                                   input logic [15:0] p);
    is_data = (a == p + `SCFG_PORT_DATA_OFS);
  endfunction

  function automatic logic [2:0] ldn_slot(input logic [7:0] n);
    if (n <= `SCFG_LDN_CHAN_MAX) begin
      ldn_slot = n[2:0];
    end else if (n == `SCFG_LDN_WDT) begin
      ldn_slot = `SCFG_SLOT_WDT;
    end else begin
      ldn_slot = `SCFG_SLOT_NONE;
    end
  endfunction

  assign slot = ldn_slot(ldn);

  // read mux: unmapped indices and slots read as zero
  always_comb begin
    rd_val = `SCFG_ZERO_BYTE;
    if (is_index(addr, port)) begin
      rd_val = index;
    end else if (index == `SCFG_IDX_LDN) begin
      rd_val = ldn;
    end else if (slot != `SCFG_SLOT_NONE) begin
      unique case (index)
        `SCFG_IDX_ENABLE: rd_val = regs[slot].enable;
        `SCFG_IDX_BASE_HI: rd_val = regs[slot].base_hi;
        `SCFG_IDX_BASE_LO: rd_val = regs[slot].base_lo;
        `SCFG_IDX_IRQ: rd_val = regs[slot].irq;
        default: rd_val = `SCFG_ZERO_BYTE;
      endcase
    end
  end

  // bus cycle engine; a frame strobe always aborts it, restarting only on a start nibble
  always_comb begin
    next_st = st;
    next_addr = addr;
    next_wr = wr;
    next_wdat = wdat;
    next_rdat = rdat;
    cmd_wr = 1'b0;
    if (!i_lframe_n) begin
      next_st = (i_lad == `SCFG_LPC_START) ? scfg_pkg::S_CYC
                                           : scfg_pkg::S_IDLE;
    end else begin
      unique case (st)
        scfg_pkg::S_IDLE: next_st = scfg_pkg::S_IDLE;
        scfg_pkg::S_CYC: begin
          next_wr = (i_lad[3:1] == `SCFG_LPC_IO_WR);
          if (i_lad[3:1] == `SCFG_LPC_IO_RD ||
              i_lad[3:1] == `SCFG_LPC_IO_WR) begin
            next_st = scfg_pkg::S_ADR0;
          end else begin
            next_st = scfg_pkg::S_IDLE;
          end
        end
        scfg_pkg::S_ADR0, scfg_pkg::S_ADR1, scfg_pkg::S_ADR2: begin
          next_addr = {addr[11:0], i_lad};
          next_st = scfg_pkg::scfg_state_e'(st + 4'h1);
        end
        scfg_pkg::S_ADR3: begin
          next_addr = {addr[11:0], i_lad};
          // claim only the index port, and the data port while open
          if (loaded && (is_index(next_addr, port) ||
              (open && is_data(next_addr, port)))) begin
            next_st = wr ? scfg_pkg::S_WD0 : scfg_pkg::S_TAR0;
          end else begin
            next_st = scfg_pkg::S_IDLE;
          end
        end
        scfg_pkg::S_WD0: begin
          next_wdat = {wdat[7:4], i_lad};
          next_st = scfg_pkg::S_WD1;
        end
        scfg_pkg::S_WD1: begin
          next_wdat = {i_lad, wdat[3:0]};
          next_st = scfg_pkg::S_TAR0;
        end
        scfg_pkg::S_TAR0: next_st = scfg_pkg::S_TAR1;
        scfg_pkg::S_TAR1: begin
          next_rdat = rd_val;
          next_st = scfg_pkg::S_SYNC;
        end
        scfg_pkg::S_SYNC: begin
          cmd_wr = wr;
          next_st = wr ? scfg_pkg::S_TARD : scfg_pkg::S_RD0;
        end
        scfg_pkg::S_RD0: next_st = scfg_pkg::S_RD1;
        scfg_pkg::S_RD1: next_st = scfg_pkg::S_TARD;
        scfg_pkg::S_TARD: next_st = scfg_pkg::S_IDLE;
        default: next_st = scfg_pkg::S_IDLE;
      endcase
    end
    // outputs are registered, so drive from the state being entered
    next_lad_oe = 1'b1;
    unique case (next_st)
      scfg_pkg::S_SYNC: next_lad = `SCFG_LPC_SYNC_OK;
      scfg_pkg::S_RD0: next_lad = rdat[3:0];
      scfg_pkg::S_RD1: next_lad = rdat[7:4];
      scfg_pkg::S_TARD: next_lad = `SCFG_LPC_TAR;
      default: begin
        next_lad = `SCFG_LPC_TAR;
        next_lad_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= scfg_pkg::S_IDLE;
      addr <= '0;
      wr <= 1'b0;
      wdat <= '0;
      rdat <= '0;
      lad <= `SCFG_LPC_TAR;
      lad_oe <= 1'b0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      wr <= next_wr;
      wdat <= next_wdat;
      rdat <= next_rdat;
      lad <= next_lad;
      lad_oe <= next_lad_oe;
    end
  end

  // configuration state and register file
  always_comb begin
    next_loaded = loaded;
    next_open = open;
    next_key_seen = key_seen;
    next_index = index;
    next_ldn = ldn;
    next_key = key;
    next_port = port;
    next_regs = regs;
    if (!loaded) begin
      // straps are taken on the first edge after reset release
      next_regs = dflt;
      next_key = dkey;
      next_port = dport;
      next_loaded = 1'b1;
    end else if (cmd_wr && is_index(addr, port)) begin
      if (!open) begin
        if (wdat == key) begin
          next_key_seen = !key_seen;
          next_open = key_seen;
        end else begin
          next_key_seen = 1'b0;
        end
      end else if (wdat == `SCFG_EXIT_CODE) begin
        next_open = 1'b0;
      end else begin
        next_index = wdat;
      end
    end else if (cmd_wr && is_data(addr, port) && open) begin
      if (index == `SCFG_IDX_LDN) begin
        next_ldn = wdat;
      end else if (slot != `SCFG_SLOT_NONE) begin
        unique case (index)
          `SCFG_IDX_ENABLE: next_regs[slot].enable = wdat;
          `SCFG_IDX_BASE_HI: next_regs[slot].base_hi = wdat;
          `SCFG_IDX_BASE_LO: next_regs[slot].base_lo = wdat;
          `SCFG_IDX_IRQ: next_regs[slot].irq = wdat;
          default: next_regs = regs;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      loaded <= 1'b0;
      open <= 1'b0;
      key_seen <= 1'b0;
      index <= '0;
      ldn <= '0;
      key <= '0;
      port <= '0;
      regs <= '0;
    end else begin
      loaded <= next_loaded;
      open <= next_open;
      key_seen <= next_key_seen;
      index <= next_index;
      ldn <= next_ldn;
      key <= next_key;
      port <= next_port;
      regs <= next_regs;
    end
  end

  assign o_lad = lad;
  assign o_lad_oe = lad_oe;
  assign o_cfg_open = open;
  assign o_chan_cfg = regs;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  strap_load_a: assert property (
    $rose(loaded) |-> regs == $past(dflt))
    else $error("registers not loaded from straps");
  chan_d_dflt_a: assert property (
    $rose(loaded) && $past(i_strap.chan_d_default_strap) |->
      regs[`SCFG_SLOT_D].base_lo == `SCFG_D_LO &&
      regs[`SCFG_SLOT_D].irq == `SCFG_D_IRQ)
    else $error("channel D default wrong");
  chan_b_prio_a: assert property (
    $rose(loaded) && $past(i_strap.chan_b_default_strap) |->
      regs[`SCFG_SLOT_B].base_lo == `SCFG_B_DEF_LO)
    else $error("channel B default strap lost priority");
  chan_a_prio_a: assert property (
    $rose(loaded) && $past(i_strap.chan_a_default_strap) |->
      regs[`SCFG_SLOT_A].base_lo == `SCFG_A_DEF_LO)
    else $error("channel A default strap lost priority");
  sw_write_a: assert property (
    cmd_wr && open && is_data(addr, port) && index == `SCFG_IDX_IRQ &&
      slot != `SCFG_SLOT_NONE |=> regs[$past(slot)].irq == $past(wdat))
    else $error("software write did not land");
  port_sel_a: assert property (
    $rose(loaded) |-> port == ($past(i_strap.config_port_select_strap) ?
      `SCFG_PORT_DEF : `SCFG_PORT_ALT))
    else $error("port pair not chosen by strap");
  key_sel_a: assert property (
    $rose(loaded) && $past(i_strap.entry_key_strap_hi) &&
      $past(i_strap.entry_key_strap_lo) |-> key == `SCFG_KEY_11)
    else $error("default entry key wrong");
  key_unlock_a: assert property (
    $rose(open) |-> $past(key_seen) && $past(wdat) == key)
    else $error("access opened without two key writes");
  exit_close_a: assert property (
    cmd_wr && open && is_index(addr, port) && wdat == `SCFG_EXIT_CODE
      |=> !open)
    else $error("exit code did not close access");
  data_gate_a: assert property (
    loaded && !open |=> $stable(regs))
    else $error("registers changed while closed");
  sync_drive_a: assert property (
    st == scfg_pkg::S_SYNC |-> lad_oe && lad == `SCFG_LPC_SYNC_OK)
    else $error("sync not driven");

endmodule

// ---- hdl/scfg_map.svh ----
/*
  Register indices, strap defaults, port addresses, keys and bus nibble
  codes of the strap loader and configuration unlock port.
  Assumes it is included by bare name, once per compilation unit.
*/
`ifndef SCFG_MAP_SVH
`define SCFG_MAP_SVH

// configuration register indices
`define SCFG_IDX_LDN      8'h07
`define SCFG_IDX_ENABLE   8'h30
`define SCFG_IDX_BASE_HI  8'h60
`define SCFG_IDX_BASE_LO  8'h61
`define SCFG_IDX_IRQ      8'h70

// logical device numbers and register slots
`define SCFG_LDN_WDT      8'h08
`define SCFG_LDN_CHAN_MAX 8'h03
`define SCFG_SLOT_WDT     3'h4
`define SCFG_SLOT_NONE    3'h7
`define SCFG_SLOT_A       3'h0
`define SCFG_SLOT_B       3'h1
`define SCFG_SLOT_C       3'h2
`define SCFG_SLOT_D       3'h3

// strapped defaults
`define SCFG_EN_ON        8'h01
`define SCFG_D_HI         8'h02
`define SCFG_D_LO         8'he8
`define SCFG_D_IRQ        8'h09
`define SCFG_C_HI         8'h03
`define SCFG_C_LO         8'he8
`define SCFG_C_IRQ        8'h05
`define SCFG_B_ALT_HI     8'h02
`define SCFG_B_ALT_LO     8'he0
`define SCFG_B_DEF_HI     8'h02
`define SCFG_B_DEF_LO     8'hf8
`define SCFG_B_IRQ        8'h04
`define SCFG_A_ALT_HI     8'h03
`define SCFG_A_ALT_LO     8'he0
`define SCFG_A_DEF_HI     8'h03
`define SCFG_A_DEF_LO     8'hf8
`define SCFG_A_IRQ        8'h03
`define SCFG_W_HI         8'h04
`define SCFG_W_LO         8'h42
`define SCFG_W_IRQ        8'h00

// configuration port pairs
`define SCFG_PORT_ALT     16'h004e
`define SCFG_PORT_DEF     16'h002e
`define SCFG_PORT_DATA_OFS 16'h0001

// entry keys by {key_hi, key_lo}, and the exit code
`define SCFG_KEY_00       8'h77
`define SCFG_KEY_01       8'ha0
`define SCFG_KEY_10       8'h87
`define SCFG_KEY_11       8'h67
`define SCFG_EXIT_CODE    8'haa

// bus nibble codes
`define SCFG_LPC_START    4'h0
`define SCFG_LPC_IO_RD    3'h0
`define SCFG_LPC_IO_WR    3'h1
`define SCFG_LPC_SYNC_OK  4'h0
`define SCFG_LPC_TAR      4'hf
`define SCFG_ZERO_BYTE    8'h00

`endif

// ---- hdl/scfg_pkg.sv ----
/*
  Types of the strap loader: strap group, per-slot configuration record
  and bus cycle states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scfg_pkg;

  typedef logic [7:0] scfg_byte_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] base_hi;
    logic [7:0] base_lo;
    logic [7:0] irq;
  } scfg_chan_s;

  typedef struct packed {
    logic chan_d_default_strap;
    logic chan_c_default_strap;
    logic chan_b_alt_strap;
    logic chan_b_default_strap;
    logic chan_a_alt_strap;
    logic chan_a_default_strap;
    logic watchdog_default_strap;
    logic config_port_select_strap;
    logic entry_key_strap_hi;
    logic entry_key_strap_lo;
  } scfg_strap_s;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CYC  = 4'b0001,
    S_ADR0 = 4'b0010,
    S_ADR1 = 4'b0011,
    S_ADR2 = 4'b0100,
    S_ADR3 = 4'b0101,
    S_WD0  = 4'b0110,
    S_WD1  = 4'b0111,
    S_TAR0 = 4'b1000,
    S_TAR1 = 4'b1001,
    S_SYNC = 4'b1010,
    S_RD0  = 4'b1011,
    S_RD1  = 4'b1100,
    S_TARD = 4'b1101
  } scfg_state_e;

endpackage

// ---- hdl/scfg_strap_dec.sv ----
/*
  Strap decoder: turns the strap pins into per-slot register defaults,
  the entry key and the configuration index port address.
  Assumes the pins carry external or internal pull-ups and are steady
  while the loader samples them.
*/
`timescale 1ns/10ps
`include "scfg_map.svh"

module scfg_strap_dec (
  input wire scfg_pkg::scfg_strap_s i_strap,
  output scfg_pkg::scfg_chan_s [4:0] o_dflt,
  output logic [7:0] o_key,
  output logic [15:0] o_index_port
);

  always_comb begin
    o_dflt = '0;
    // a slot whose straps are all low is left all zero
    if (i_strap.chan_d_default_strap) begin
      o_dflt[`SCFG_SLOT_D] = {`SCFG_EN_ON, `SCFG_D_HI, `SCFG_D_LO,
                             `SCFG_D_IRQ};
    end
    if (i_strap.chan_c_default_strap) begin
      o_dflt[`SCFG_SLOT_C] = {`SCFG_EN_ON, `SCFG_C_HI, `SCFG_C_LO,
                             `SCFG_C_IRQ};
    end
    if (i_strap.watchdog_default_strap) begin
      o_dflt[`SCFG_SLOT_WDT] = {`SCFG_EN_ON, `SCFG_W_HI, `SCFG_W_LO,
                               `SCFG_W_IRQ};
    end
    // the default strap wins over the alternate one
    if (i_strap.chan_b_default_strap) begin
      o_dflt[`SCFG_SLOT_B] = {`SCFG_EN_ON, `SCFG_B_DEF_HI, `SCFG_B_DEF_LO,
                             `SCFG_B_IRQ};
    end else if (i_strap.chan_b_alt_strap) begin
      o_dflt[`SCFG_SLOT_B] = {`SCFG_EN_ON, `SCFG_B_ALT_HI, `SCFG_B_ALT_LO,
                             `SCFG_B_IRQ};
    end
    if (i_strap.chan_a_default_strap) begin
      o_dflt[`SCFG_SLOT_A] = {`SCFG_EN_ON, `SCFG_A_DEF_HI, `SCFG_A_DEF_LO,
                             `SCFG_A_IRQ};
    end else if (i_strap.chan_a_alt_strap) begin
      o_dflt[`SCFG_SLOT_A] = {`SCFG_EN_ON, `SCFG_A_ALT_HI, `SCFG_A_ALT_LO,
                             `SCFG_A_IRQ};
    end
    // an open pin pulls up, so the default pair is the low one
    o_index_port = i_strap.config_port_select_strap ? `SCFG_PORT_DEF
                                                    : `SCFG_PORT_ALT;
    unique case ({i_strap.entry_key_strap_hi, i_strap.entry_key_strap_lo})
      2'b00: o_key = `SCFG_KEY_00;
      2'b01: o_key = `SCFG_KEY_01;
      2'b10: o_key = `SCFG_KEY_10;
      2'b11: o_key = `SCFG_KEY_11;
    endcase
  end

endmodule

// ---- verif/scfg_host_model.sv ----
/*
  Host model of the bus: issues I/O reads and writes on the four-bit
  lines with frame, turnaround and a bounded wait for sync.
  Assumes the lines are resolved outside, with pull-ups to 4'hf.
*/
`timescale 1ns/10ps
module scfg_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_lad,
  output logic o_lframe_n,
  output logic [3:0] o_lad,
  output logic o_lad_en
);
  initial begin
    o_lframe_n = 1'b1;
    o_lad = 4'hf;
    o_lad_en = 1'b0;
  end
  // one nibble per cycle, changed just after the edge
  task automatic put(input logic [3:0] nib, input logic frame_n);
    @(posedge i_clk);
    #1;
    o_lframe_n = frame_n;
    o_lad = nib;
    o_lad_en = 1'b1;
  endtask
  // config traffic only as index/data port cycles
  task automatic io(input logic wr, input logic [15:0] a,
                    input logic [7:0] d, output logic [7:0] q,
                    output logic hit);
    int i;
    hit = 1'b0;
    q = 8'h00;
    put(4'h0, 1'b0);
    put(wr ? 4'h2 : 4'h0, 1'b1);
    for (i = 3; i >= 0; i--) put(a[i*4 +: 4], 1'b1);
    if (wr) begin
      put(d[3:0], 1'b1);
      put(d[7:4], 1'b1);
    end
    put(4'hf, 1'b1);
    @(posedge i_clk);
    #1;
    o_lad_en = 1'b0;
    // unclaimed cycles never sync; give up after four edges
    for (i = 0; i < 4 && !hit; i++) begin
      @(posedge i_clk);
      if (i_lad === 4'h0) hit = 1'b1;
    end
    if (hit) begin
      if (!wr) begin
        @(posedge i_clk);
        q[3:0] = i_lad;
        @(posedge i_clk);
        q[7:4] = i_lad;
      end
      @(posedge i_clk);
    end
  endtask
endmodule

// ---- verif/strap_config_port_unlock_test.sv ----
/*
  Self-checking bench of the strap loader and unlock port.
  Assumes scfg_loader with five slots and the host model beside it.
*/
`timescale 1ns/10ps
module strap_config_port_unlock_test;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  scfg_pkg::scfg_strap_s i_strap = '1;
  logic lframe_n;
  logic [3:0] host_lad;
  logic host_en;
  logic [3:0] o_lad;
  logic o_lad_oe;
  logic o_cfg_open;
  scfg_pkg::scfg_chan_s [4:0] o_chan_cfg;
  wire logic [3:0] lad_w;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  // released lines float up to all ones
  assign lad_w = o_lad_oe ? o_lad : (host_en ? host_lad : 4'hf);
  always #2 i_sys_clk = ~i_sys_clk;
  scfg_loader #(.NSLOT(5)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_strap(i_strap),
    .i_lframe_n(lframe_n), .i_lad(lad_w), .o_lad(o_lad),
    .o_lad_oe(o_lad_oe), .o_cfg_open(o_cfg_open),
    .o_chan_cfg(o_chan_cfg)
  );
  scfg_host_model host_u (
    .i_clk(i_sys_clk), .i_lad(lad_w), .o_lframe_n(lframe_n),
    .o_lad(host_lad), .o_lad_en(host_en)
  );
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // whole run needs about 800 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    output logic hit);
    logic [7:0] q;
    host_u.io(1'b1, a, d, q, hit);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q,
                    output logic hit);
    host_u.io(1'b0, a, 8'h00, q, hit);
    #1;
  endtask
  function automatic logic [31:0] exp_cfg(input scfg_pkg::scfg_strap_s s,
                                          input int n);
    case (n)
      0: return s.chan_a_default_strap ? 32'h0103f803 :
                s.chan_a_alt_strap ? 32'h0103e003 : 32'h0;
      1: return s.chan_b_default_strap ? 32'h0102f804 :
                s.chan_b_alt_strap ? 32'h0102e004 : 32'h0;
      2: return s.chan_c_default_strap ? 32'h0103e805 : 32'h0;
      3: return s.chan_d_default_strap ? 32'h0102e809 : 32'h0;
      default: return s.watchdog_default_strap ? 32'h01044200 : 32'h0;
    endcase
  endfunction
  function automatic logic [7:0] exp_key(input scfg_pkg::scfg_strap_s s);
    case ({s.entry_key_strap_hi, s.entry_key_strap_lo})
      2'b00: return 8'h77;
      2'b01: return 8'ha0;
      2'b10: return 8'h87;
      default: return 8'h67;
    endcase
  endfunction
  task automatic do_reset(input scfg_pkg::scfg_strap_s s);
    @(posedge i_sys_clk);
    #1;
    i_strap = s;
    i_rst = 1'b1;
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic t_load(input scfg_pkg::scfg_strap_s s);
    int n;
    do_reset(s);
    for (n = 0; n < 5; n++) begin
      chk("slot cfg", exp_cfg(s, n),
          o_chan_cfg[n]);
    end
  endtask
  task automatic t_unlock(input scfg_pkg::scfg_strap_s s);
    logic [15:0] ip;
    logic [7:0] k;
    logic [7:0] q;
    logic hit;
    ip = s.config_port_select_strap ? 16'h002e : 16'h004e;
    k = exp_key(s);
    wr(ip ^ 16'h0060, k, hit);
    chk("other pair claim", 32'h0, {31'h0, hit});
    wr(ip ^ 16'h0060, k, hit);
    chk("open via other pair", 32'h0, {31'h0, o_cfg_open});
    rd(ip + 16'h0001, q, hit);
    chk("closed data claim", 32'h0, {31'h0, hit});
    wr(ip, k, hit);
    chk("index claim", 32'h1, {31'h0, hit});
    chk("open after one key", 32'h0, {31'h0, o_cfg_open});
    wr(ip, k ^ 8'h10, hit);
    wr(ip, k, hit);
    chk("open after broken pair", 32'h0, {31'h0, o_cfg_open});
    wr(ip, k, hit);
    chk("open after key pair", 32'h1, {31'h0, o_cfg_open});
    rd(ip + 16'h0001, q, hit);
    chk("open data claim", 32'h1, {31'h0, hit});
    chk("unmapped read", 32'h0, {24'h0, q});
    wr(ip, 8'haa, hit);
    chk("open after exit", 32'h0, {31'h0, o_cfg_open});
  endtask
  task automatic t_regs;
    logic [15:0] a [15];
    logic [7:0] d [15];
    logic [7:0] q;
    logic hit;
    int i;
    a = '{16'h2e, 16'h2f, 16'h2e, 16'h2f, 16'h2e, 16'h2f, 16'h2e, 16'h2f,
          16'h2e, 16'h2f, 16'h2e, 16'h2f, 16'h2e, 16'h2f, 16'h2e};
    d = '{8'h07, 8'h00, 8'h60, 8'h12, 8'h61, 8'h34, 8'h30, 8'h00,
          8'h70, 8'h07, 8'h07, 8'h08, 8'h60, 8'h05, 8'haa};
    do_reset('1);
    wr(16'h002e, 8'h67, hit);
    wr(16'h002e, 8'h67, hit);
    for (i = 0; i < 10; i++) wr(a[i], d[i], hit);
    chk("slot A written", 32'h00123407, o_chan_cfg[0]);
    rd(16'h002f, q, hit);
    chk("irq select read", 32'h07, {24'h0, q});
    rd(16'h002e, q, hit);
    chk("index read", 32'h70, {24'h0, q});
    for (i = 10; i < 15; i++) wr(a[i], d[i], hit);
    chk("wdt base high", 32'h05, {24'h0, o_chan_cfg[4].base_hi});
    chk("slot A kept", 32'h00123407, o_chan_cfg[0]);
    wr(16'h002f, 8'h99, hit);
    chk("closed data write", 32'h0, {31'h0, hit});
    chk("wdt after closed", 32'h05, {24'h0, o_chan_cfg[4].base_hi});
  endtask
  initial begin
    scfg_pkg::scfg_strap_s pats [4];
    int p;
    pats = '{10'h3ff, 10'h000, 10'h2a9, 10'h156};
    for (p = 0; p < 4; p++) begin
      t_load(pats[p]);
      t_unlock(pats[p]);
    end
    t_regs();
    summarize();
  end
endmodule
